// ---- shared/mux_seq_cfg_pkg.sv ----
/*
  Constants shared by the sequencer step configuration bank and its decoder:
  register addresses, field positions, reset words and source codes.
  Assumes an 8-bit register address space with 16-bit register words.
*/
`default_nettype none

package mux_seq_cfg_pkg;

   // Register map
   localparam logic [7:0] ADDR_STEP13 = 8'h9D; // Step 13 configuration word
   localparam logic [7:0] ADDR_STEP14 = 8'h9E; // Step 14 configuration word

   // Reset words
   localparam logic [15:0] RESET_STEP13 = 16'h000D; // Disabled, gain 1, ground, code 1101b
   localparam logic [15:0] RESET_STEP14 = 16'h000E; // Disabled, gain 1, ground, code 1110b

   // Field positions
   localparam int EN_BIT = 15;
   localparam int GAIN_HI = 14;
   localparam int GAIN_LO = 13;
   localparam int RSVD_HI = 12;
   localparam int RSVD_LO = 5;
   localparam int NEG_BIT = 4;
   localparam int POS_HI = 3;
   localparam int POS_LO = 0;

   // Bits that software may change; reserved bits stay zero
   localparam logic [15:0] WRITE_MASK = 16'hE01F;

   // Step numbers served by this bank
   localparam logic [3:0] STEP_A = 4'hD;
   localparam logic [3:0] STEP_B = 4'hE;

   // Gain field codes and the gain factors they select
   localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
   localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
   localparam logic [2:0] GAIN_X1 = 3'h1;
   localparam logic [2:0] GAIN_X2 = 3'h2;
   localparam logic [2:0] GAIN_X4 = 3'h4;

   // Positive selector codes for the last external input and internal sources
   localparam logic [3:0] POS_EXT_LAST = 4'h7; // External input seven
   localparam logic [3:0] POS_TEMP = 4'h8; // Temperature sensor
   localparam logic [3:0] POS_SHORT = 4'h9; // Internal short to ground
   localparam logic [3:0] POS_TEST_DAC = 4'hA; // Test DAC

   // Class of the positive source, as reported to the converter
   typedef enum logic [2:0] {
      SRC_EXTERNAL,
      SRC_TEMP,
      SRC_SHORT,
      SRC_TEST_DAC,
      SRC_SUPPLY
   } src_class_t;

endpackage : mux_seq_cfg_pkg

`default_nettype wire

// ---- rtl/step_cfg_decode.sv ----
/*
  Combinational decoder that turns one stored step configuration word
  into the gain factor and input selections used by the converter.
  Assumes the word already has its reserved bits cleared.
*/
`default_nettype none

module step_cfg_decode
   import mux_seq_cfg_pkg::*;
(
   input wire logic [15:0] cfg_word,
   output logic enable,
   output logic [2:0] gain_factor,
   output logic [3:0] pos_sel,
   output logic neg_ext7,
   output logic neg_auto,
   output src_class_t src_class
);

   // Field split and source decode
   always_comb begin
      enable = cfg_word[EN_BIT];
      pos_sel = cfg_word[POS_HI:POS_LO];
      // Gain: both upper codes fall back to four
      case (cfg_word[GAIN_HI:GAIN_LO])
         GAIN_CODE_X1: gain_factor = GAIN_X1;
         GAIN_CODE_X2: gain_factor = GAIN_X2;
         default: gain_factor = GAIN_X4;
      endcase
      // Every code above the last external input is internal
      neg_auto = (pos_sel > POS_EXT_LAST);
      // Negative select bit only counts for external positive inputs
      neg_ext7 = cfg_word[NEG_BIT] & ~neg_auto;
      // Unlisted internal codes are grouped as scaled supplies
      case (pos_sel)
         POS_TEMP: src_class = SRC_TEMP;
         POS_SHORT: src_class = SRC_SHORT;
         POS_TEST_DAC: src_class = SRC_TEST_DAC;
         default: src_class = neg_auto ? SRC_SUPPLY : SRC_EXTERNAL;
      endcase
   end

endmodule // step_cfg_decode

`default_nettype wire

// ---- rtl/mux_adc_seq_step_config.sv ----
/*
  Configuration bank for sequencer steps 13 and 14 of the auxiliary
  multiplexed converter, with a plain register port and a step request
  port from the sequencer engine.
  Assumes one clock, synchronous active-low reset, and a register master
  that never issues read and write strobes in the same cycle.
*/
// The strobed register port was decided locally.
`default_nettype none

// Summary of operation
// - Bit 15 enables step 13
// - Gain field: 1, 2, 4, 4
// - Bits 12:5 always read zero
// - Bit 4: ground or input seven
// - Positive codes 0-7 pick external inputs
// - Codes 8-15 internal, negative chosen automatically
// - Negative bit ignored for internal sources
// - Step 13 resets to 000Dh at 9Dh
module mux_adc_seq_step_config
   import mux_seq_cfg_pkg::*;
#(
   parameter int NUM_STEPS = 2 // Steps held by this bank
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic seq_step_valid,
   input wire logic [3:0] seq_step_num,
   output logic conv_start,
   output logic step_skip,
   output logic [3:0] conv_step_num,
   output logic [2:0] conv_gain,
   output logic [3:0] conv_pos_sel,
   output logic conv_neg_ext7,
   output logic conv_neg_auto,
   output src_class_t conv_src_class
);

   // Per-step tables, indexed by slot
   localparam logic [7:0] SLOT_ADDR [NUM_STEPS] = '{ADDR_STEP13, ADDR_STEP14};
   localparam logic [15:0] SLOT_RESET [NUM_STEPS] = '{RESET_STEP13, RESET_STEP14};
   localparam logic [3:0] SLOT_STEP [NUM_STEPS] = '{STEP_A, STEP_B};

   // Stored configuration words, reserved bits held at zero
   logic [15:0] cfg_q [NUM_STEPS];
   logic [15:0] cfg_d [NUM_STEPS];

   // Decoded view of each slot
   logic [NUM_STEPS-1:0] dec_enable;
   logic [2:0] dec_gain [NUM_STEPS];
   logic [3:0] dec_pos [NUM_STEPS];
   logic [NUM_STEPS-1:0] dec_neg_ext7;
   logic [NUM_STEPS-1:0] dec_neg_auto;
   src_class_t dec_class [NUM_STEPS];

   // Address and step matches per slot
   logic [NUM_STEPS-1:0] addr_hit;
   logic [NUM_STEPS-1:0] step_hit;

   // Read data register
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // Converter command registers
   logic start_q, start_d;
   logic skip_q, skip_d;
   logic [3:0] stepn_q, stepn_d;
   logic [2:0] gain_q, gain_d;
   logic [3:0] pos_q, pos_d;
   logic neg7_q, neg7_d;
   logic auto_q, auto_d;
   src_class_t class_q, class_d;

   // One storage slot and decoder per step
   genvar s;
   generate
      for (s = 0; s < NUM_STEPS; s++) begin : g_slot
         // Address decode and masked write of this slot
         always_comb begin
            addr_hit[s] = (reg_addr == SLOT_ADDR[s]);
            step_hit[s] = (seq_step_num == SLOT_STEP[s]);
            cfg_d[s] = cfg_q[s];
            if (reg_wr && addr_hit[s]) begin
               // Reserved bits are forced to zero on every write
               cfg_d[s] = reg_wdata & WRITE_MASK;
            end
         end

         // Storage; reset word loaded on reset
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               cfg_q[s] <= SLOT_RESET[s];
            end else begin
               cfg_q[s] <= cfg_d[s];
            end
         end

         // Field decode for the converter
         step_cfg_decode u_decode (
            .cfg_word(cfg_q[s]),
            .enable(dec_enable[s]),
            .gain_factor(dec_gain[s]),
            .pos_sel(dec_pos[s]),
            .neg_ext7(dec_neg_ext7[s]),
            .neg_auto(dec_neg_auto[s]),
            .src_class(dec_class[s])
         );
      end
   endgenerate

   // Read mux; unmapped addresses and idle cycles give zero
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd) begin
         for (int i = 0; i < NUM_STEPS; i++) begin
            if (addr_hit[i]) begin
               rdata_d = cfg_q[i] & WRITE_MASK;
            end
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Step request handling; the word stored before this edge is used,
   // so a write in the same cycle only affects the next request
   always_comb begin
      start_d = 1'b0;
      skip_d = 1'b0;
      stepn_d = stepn_q;
      gain_d = gain_q;
      pos_d = pos_q;
      neg7_d = neg7_q;
      auto_d = auto_q;
      class_d = class_q;
      if (seq_step_valid) begin
         for (int i = 0; i < NUM_STEPS; i++) begin
            if (step_hit[i]) begin
               stepn_d = seq_step_num;
               if (dec_enable[i]) begin
                  // Enabled: launch with the stored selections
                  start_d = 1'b1;
                  gain_d = dec_gain[i];
                  pos_d = dec_pos[i];
                  neg7_d = dec_neg_ext7[i];
                  auto_d = dec_neg_auto[i];
                  class_d = dec_class[i];
               end else begin
                  // Disabled: tell the engine to move on
                  skip_d = 1'b1;
               end
            end
         end
      end
   end

   // Command registers; selections hold until the next launch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_q <= 1'b0;
         skip_q <= 1'b0;
         stepn_q <= 4'h0;
         gain_q <= GAIN_X1;
         pos_q <= 4'h0;
         neg7_q <= 1'b0;
         auto_q <= 1'b0;
         class_q <= SRC_EXTERNAL;
      end else begin
         start_q <= start_d;
         skip_q <= skip_d;
         stepn_q <= stepn_d;
         gain_q <= gain_d;
         pos_q <= pos_d;
         neg7_q <= neg7_d;
         auto_q <= auto_d;
         class_q <= class_d;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_q;
   assign conv_start = start_q;
   assign step_skip = skip_q;
   assign conv_step_num = stepn_q;
   assign conv_gain = gain_q;
   assign conv_pos_sel = pos_q;
   assign conv_neg_ext7 = neg7_q;
   assign conv_neg_auto = auto_q;
   assign conv_src_class = class_q;

   // Reserved bits of step 13 never read back as ones
   chk_reserved_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == ADDR_STEP13) |=> (reg_rdata[RSVD_HI:RSVD_LO] == 8'h00))
      else $error("reserved bits read nonzero");

   // First read after reset returns the reset word
   chk_reset_word: assert property (
      @(posedge clk)
      (!rst_n ##1 (rst_n && reg_rd && reg_addr == ADDR_STEP13))
      |=> (reg_rdata == RESET_STEP13))
      else $error("step 13 reset word wrong");

   // Written value reads back with reserved bits cleared
   chk_write_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ADDR_STEP13) ##1 (reg_rd && reg_addr == ADDR_STEP13)
      |=> (reg_rdata == ($past(reg_wdata, 2) & WRITE_MASK)))
      else $error("step 13 readback mismatch");

   // Enabled step 13 launches a conversion next cycle
   chk_enabled_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      (seq_step_valid && seq_step_num == STEP_A && cfg_q[0][EN_BIT])
      |=> (conv_start && !step_skip && conv_step_num == STEP_A))
      else $error("enabled step did not start");

   // Disabled step 13 is skipped, no conversion
   chk_disabled_skip: assert property (
      @(posedge clk) disable iff (!rst_n)
      (seq_step_valid && seq_step_num == STEP_A && !cfg_q[0][EN_BIT])
      |=> (step_skip && !conv_start))
      else $error("disabled step not skipped");

   // Gain follows the stored field: 1, 2, else 4
   chk_gain_map: assert property (
      @(posedge clk) disable iff (!rst_n)
      (seq_step_valid && seq_step_num == STEP_A && cfg_q[0][EN_BIT])
      |=> (conv_gain == (($past(cfg_q[0][GAIN_HI:GAIN_LO]) == 2'h0) ? 3'h1 :
                         ($past(cfg_q[0][GAIN_HI:GAIN_LO]) == 2'h1) ? 3'h2 : 3'h4)))
      else $error("gain mapping wrong");

   // Internal sources never route input seven to the negative side
   chk_neg_ignored: assert property (
      @(posedge clk) disable iff (!rst_n)
      (conv_start && conv_pos_sel[3]) |-> (conv_neg_auto && !conv_neg_ext7))
      else $error("negative bit honoured for internal source");

   // External positive codes carry the stored negative bit
   chk_neg_external: assert property (
      @(posedge clk) disable iff (!rst_n)
      (seq_step_valid && seq_step_num == STEP_A && cfg_q[0][EN_BIT] && !cfg_q[0][3])
      |=> (!conv_neg_auto && conv_neg_ext7 == $past(cfg_q[0][NEG_BIT])))
      else $error("negative select not applied");

   // Positive code passes unchanged; internal codes flagged
   chk_pos_pass: assert property (
      @(posedge clk) disable iff (!rst_n)
      (seq_step_valid && seq_step_num == STEP_A && cfg_q[0][EN_BIT])
      |=> (conv_pos_sel == $past(cfg_q[0][POS_HI:POS_LO])
           && conv_neg_auto == $past(cfg_q[0][3])))
      else $error("positive select wrong");

   // Launch only comes in the cycle after a step request
   chk_start_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      (conv_start && !$past(seq_step_valid)) |-> 1'b0)
      else $error("start without a request");

endmodule // mux_adc_seq_step_config

`default_nettype wire

// ---- verification/mux_adc_seq_step_config_tb.sv ----
/*
  Self-checking bench for the step configuration bank: register port
  reads and writes, reset words, and step requests for steps 13 and 14.
  Assumes the bank answers reads and steps exactly one cycle later.
*/
`default_nettype none

module mux_adc_seq_step_config_tb
   import mux_seq_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst_n, reg_wr, reg_rd, seq_step_valid; // Bench-driven controls
   logic [7:0] reg_addr; // Register address
   logic [15:0] reg_wdata, reg_rdata, w; // Bus data and scratch word
   logic [3:0] seq_step_num, conv_step_num, conv_pos_sel, n; // Step and source codes
   logic [2:0] conv_gain; // Gain factor seen
   logic conv_start, step_skip, conv_neg_ext7, conv_neg_auto; // Step answers
   src_class_t conv_src_class; // Source class seen
   int n_mismatch, n_tests, cycles; // Counters

   mux_adc_seq_step_config u_mux_adc_seq_step_config (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .seq_step_valid(seq_step_valid), .seq_step_num(seq_step_num),
      .conv_start(conv_start), .step_skip(step_skip), .conv_step_num(conv_step_num),
      .conv_gain(conv_gain), .conv_pos_sel(conv_pos_sel), .conv_neg_ext7(conv_neg_ext7),
      .conv_neg_auto(conv_neg_auto), .conv_src_class(conv_src_class));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Cut a hang short; the whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Compare a word or a narrow field, zero-extended
   task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Compare a one-bit flag
   task automatic cmp_flag(input string what, input logic exp, input logic got);
      cmp_word(what, {15'h0, exp}, {15'h0, got});
   endtask

   // Gain factor expected for a gain field code
   function automatic logic [2:0] exp_gain(input logic [1:0] c);
      if (c == GAIN_CODE_X1) return GAIN_X1;
      if (c == GAIN_CODE_X2) return GAIN_X2;
      return GAIN_X4; // Both upper codes give four
   endfunction

   // Source class expected for a positive code
   function automatic src_class_t exp_class(input logic [3:0] p);
      if (p <= POS_EXT_LAST) return SRC_EXTERNAL;
      if (p == POS_TEMP) return SRC_TEMP;
      if (p == POS_SHORT) return SRC_SHORT;
      if (p == POS_TEST_DAC) return SRC_TEST_DAC;
      return SRC_SUPPLY;
   endfunction

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Write then read the same word with no gap, as the bus allows
   task automatic wr_rd_chk(input logic [7:0] a, input logic [15:0] d,
                            input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      // Read strobe follows at once, so the new word must already stand
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 cmp_word("rdata_b2b", exp, reg_rdata);
   endtask

   // One-cycle read strobe; data is looked at in the following cycle only
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 cmp_word("rdata", exp, reg_rdata);
   endtask

   // Request a step and check the answer against the stored word
   task automatic step_chk(input logic [3:0] num, input logic [15:0] word);
      logic served;
      served = (num == STEP_A) || (num == STEP_B);
      @(posedge clk);
      seq_step_valid <= 1'b1;
      seq_step_num <= num;
      @(posedge clk);
      seq_step_valid <= 1'b0;
      #1;
      cmp_flag("start", served & word[EN_BIT], conv_start);
      cmp_flag("skip", served & ~word[EN_BIT], step_skip);
      if (served) cmp_word("step", {12'h0, num}, {12'h0, conv_step_num});
      if (served && word[EN_BIT]) begin
         cmp_word("gain", {13'h0, exp_gain(word[GAIN_HI:GAIN_LO])}, {13'h0, conv_gain});
         cmp_word("pos", {12'h0, word[POS_HI:POS_LO]}, {12'h0, conv_pos_sel});
         cmp_flag("auto", word[3], conv_neg_auto);
         cmp_flag("neg", word[NEG_BIT] & ~word[3], conv_neg_ext7);
         cmp_word("class", {13'h0, exp_class(word[3:0])}, {13'h0, conv_src_class});
      end
      @(posedge clk);
      #1 cmp_flag("pulse", 1'b0, conv_start | step_skip);
   endtask

   // Reset held two cycles, released on an edge; a read of step 13 goes
   // out in the very first cycle out of reset, the earliest legal request
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      reg_addr <= ADDR_STEP13;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 cmp_word("rdata_rst", RESET_STEP13, reg_rdata);
      cmp_word("gain_rst", {13'h0, GAIN_X1}, {13'h0, conv_gain});
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      seq_step_valid = 1'b0;
      seq_step_num = 4'h0;
      void'($urandom(32'h057B7935));
      do_reset();
      rd_chk(ADDR_STEP13, 16'h000D);
      rd_chk(ADDR_STEP14, 16'h000E);
      step_chk(STEP_A, 16'h000D);
      wr(ADDR_STEP13, 16'hFFFF);
      rd_chk(ADDR_STEP13, 16'hE01F);
      rd_chk(8'h9C, 16'h0000);
      // Every gain code with every positive code, other bits random
      for (int i = 0; i < 64; i++) begin
         w = 16'($urandom);
         w[GAIN_HI:GAIN_LO] = i[5:4];
         w[POS_HI:POS_LO] = i[3:0];
         wr_rd_chk(ADDR_STEP13, w, w & WRITE_MASK);
         wr(8'h9F, 16'($urandom)); // Unmapped, must leave step 13 alone
         rd_chk(ADDR_STEP13, w & WRITE_MASK);
         step_chk(STEP_A, w);
         n = 4'($urandom_range(0, 12));
         step_chk(n, w);
      end
      // Step 14 with an internal supply code
      wr(ADDR_STEP14, 16'hBFFF);
      rd_chk(ADDR_STEP14, 16'hA01F);
      step_chk(STEP_B, 16'hBFFF);
      // Second reset in mid-run restores the reset word
      do_reset();
      rd_chk(ADDR_STEP13, RESET_STEP13);
      rd_chk(ADDR_STEP14, RESET_STEP14);
      give_verdict();
   end

endmodule // mux_adc_seq_step_config_tb

`default_nettype wire
